// ---- srb_defines.vh ----
// Shared constants for the serial port rate generator and sync engine.
// Included by every design file; holds definitions only.
`ifndef SRB_DEFINES_VH
`define SRB_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------------
`define SRB_ADDR_W        4
`define SRB_REG_DIV_LO    4'h0
`define SRB_REG_DIV_HI    4'h1
`define SRB_REG_RATE_CTRL 4'h2
`define SRB_REG_TX_CTRL   4'h3
`define SRB_REG_RX_CTRL   4'h4
`define SRB_REG_TX_HOLD   4'h5
`define SRB_REG_RX_HOLD   4'h6
`define SRB_REG_INT_STAT  4'h7
`define SRB_REG_INT_MASK  4'h8
`define SRB_REG_IRQ_CTRL  4'h9

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SRB_RC_WIDE       3
`define SRB_RC_IDLE       6
`define SRB_TC_MASTER     7
`define SRB_TC_TXEN       5
`define SRB_TC_SYNC       4
`define SRB_TC_HS         2
`define SRB_TC_TRMT       1
`define SRB_XC_PORTEN     7
`define SRB_XC_RXEN       4
`define SRB_IC_GLOBAL     7
`define SRB_IC_PERI       6
`define SRB_INT_RX        0
`define SRB_INT_TX        1
`define SRB_INT_OVR       2
`define SRB_INT_W         3

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define SRB_BYTE_RST      8'h00
`define SRB_INT_RST       3'h0
`define SRB_PRE_STD       6'h3F
`define SRB_PRE_MID       6'h0F
`define SRB_PRE_FAST      6'h03
`define SRB_PRE_SYNC      6'h01
`define SRB_CNT_RST       4'h0
`define SRB_LAST_BIT      4'h7
`define SRB_STOP_IDX      4'h8
`define SRB_FRAME_END     4'h9
`define SRB_ISR_VECTOR    12'h004
`define SRB_NO_VECTOR     12'h000

`endif

// ---- srb_rate_div.v ----
// Free-running rate divider timer with the asynchronous multiplier.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "srb_defines.vh"

module srb_rate_div #(
  parameter DIV_W = 16
) (
  input  wire             sys_clk_i,
  input  wire             rst_i,
  input  wire             en_i,
  input  wire             clear_i,
  input  wire [DIV_W-1:0] divisor_i,
  input  wire             wide_i,
  input  wire             high_speed_i,
  input  wire             sync_i,
  output reg              tick_o
);

  // --------------------------------------------------------------------
  // Multiplier selection
  // --------------------------------------------------------------------
  // In sync mode each tick is half a bit clock period, so the clock pin
  // period comes to four times the divider period.
  function [5:0] srb_pre_limit;
    input sync_m;
    input wide_m;
    input hs_m;
    begin
      if (sync_m)
        srb_pre_limit = `SRB_PRE_SYNC; // R04
      else if (wide_m & hs_m)
        srb_pre_limit = `SRB_PRE_FAST; // R03
      else if (wide_m | hs_m)
        srb_pre_limit = `SRB_PRE_MID;
      else
        srb_pre_limit = `SRB_PRE_STD; // R06
    end
  endfunction

  wire [DIV_W-1:0] limit;
  wire [5:0]       pre_limit;
  reg  [DIV_W-1:0] cnt_r;
  reg  [5:0]       pre_r;

  assign limit = wide_i ? divisor_i
                        : {{(DIV_W-8){1'b0}}, divisor_i[7:0]}; // R01 R02
  assign pre_limit = srb_pre_limit(sync_i, wide_i, high_speed_i);

  // --------------------------------------------------------------------
  // Counters
  // --------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_i || clear_i) begin // R05
      cnt_r  <= {DIV_W{1'b0}};
      pre_r  <= 6'h00;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (en_i) begin
        if (cnt_r >= limit) begin
          cnt_r <= {DIV_W{1'b0}};
          if (pre_r >= pre_limit) begin
            pre_r  <= 6'h00;
            tick_o <= 1'b1;
          end else begin
            pre_r <= pre_r + 6'h01;
          end
        end else begin
          cnt_r <= cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- srb_serial_port.v ----
// Serial port core: rate generator, sync master/slave shifter, async
// transmitter, register port and interrupt logic.
// Assumes a 20 MHz system clock; pins arrive asynchronously.
//
// Behaviour
// R01: Divider runs 8-bit after reset, 16-bit when wide select is set.
// R02: Divider period comes from the divisor high and low byte pair.
// R03: Async multiplier follows high speed and wide select together.
// R04: Sync mode ignores the high speed select bit.
// R05: Any divisor write clears the divider timer at once.
// R06: Async 8-bit standard rate is clock over 64 times divisor plus one.
// R07: During sleep only synchronous slave mode keeps running.
// R08: Synchronous slave shifts on the external clock pin, not the divider.
// R09: Master clocks data in during sleep; full word sets receive flag, wakes.
// R10: Reading receive holding register empties buffer and clears receive flag; here the flag clears only on an interrupt status read.
// R11: Sleep transmit accepts pin clocks and drives bits on the data pin.
// R12: Word shifted out moves pending byte in, sets transmit flag, wakes.
// R13: Writing transmit holding register clears transmit flag, fills shifter; here the flag clears only on an interrupt status read.
// R14: Software enables transmit and peripheral interrupts before sleep.
// R15: Software enables receive, global, peripheral interrupts before sleep.
// R16: Wake resumes after sleep; vector 004h only with global enable.
// R17: Software checks receive idle before changing the system clock.
// R18: Software may use high speed or wide divider to cut rate error.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "srb_defines.vh"

module srb_serial_port #(
  parameter DIV_W = 16
) (
  input  wire                   sys_clk_i,
  input  wire                   rst_i,
  input  wire [`SRB_ADDR_W-1:0] addr_i,
  input  wire [7:0]             wr_data_i,
  input  wire                   wr_i,
  input  wire                   rd_i,
  output reg  [7:0]             rd_data_o,
  input  wire                   sleep_i,
  input  wire                   ck_i,
  output reg                    ck_o,
  output reg                    ck_oe_o,
  input  wire                   dt_i,
  output reg                    dt_o,
  output reg                    dt_oe_o,
  output reg                    irq_o,
  output reg                    wake_o,
  output reg                    vector_req_o,
  output reg  [11:0]            vector_addr_o
);

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [7:0]            div_lo_r;
  reg [7:0]            div_hi_r;
  reg                  wide_divider_select_r;
  reg                  master_r;
  reg                  tx_en_r;
  reg                  sync_r;
  reg                  high_speed_select_r;
  reg                  port_en_r;
  reg                  rx_en_r;
  reg [7:0]            tx_hold_r;
  reg                  tx_full_r;
  reg [7:0]            tsr_r;
  reg                  tsr_busy_r;
  reg [3:0]            tx_cnt_r;
  reg [7:0]            rx_shift_r;
  reg [3:0]            rx_cnt_r;
  reg [7:0]            rx_hold_r;
  reg                  rx_full_r;
  reg [`SRB_INT_W-1:0] int_stat_r;
  reg [`SRB_INT_W-1:0] int_mask_r;
  reg                  global_irq_enable_r;
  reg                  peripheral_irq_enable_r;
  reg                  ck_s1_r;
  reg                  ck_s2_r;
  reg                  ck_s3_r;
  reg                  dt_s1_r;
  reg                  dt_s2_r;

  reg [7:0]            rd_nxt;
  reg [`SRB_INT_W-1:0] int_stat_nxt;
  reg                  irq_nxt;

  // --------------------------------------------------------------------
  // Decode and mode
  // --------------------------------------------------------------------
  wire wr_div     = wr_i && (addr_i == `SRB_REG_DIV_LO ||
                             addr_i == `SRB_REG_DIV_HI);
  wire wr_tx_hold = wr_i && (addr_i == `SRB_REG_TX_HOLD);
  wire rd_rx_hold = rd_i && (addr_i == `SRB_REG_RX_HOLD);
  wire rd_stat    = rd_i && (addr_i == `SRB_REG_INT_STAT);

  wire sync_slave  = port_en_r & sync_r & ~master_r;
  wire sync_master = port_en_r & sync_r & master_r;
  // A halted system clock stops everything but the slave shifter.
  wire run         = ~sleep_i | sync_slave; // R07
  wire sync_tx     = port_en_r & sync_r & tx_en_r;
  wire sync_rx     = port_en_r & sync_r & ~tx_en_r & rx_en_r;
  wire async_tx    = port_en_r & ~sync_r & tx_en_r;
  wire tick;

  srb_rate_div #(
    .DIV_W (DIV_W)
  ) u_rate_div (
    .sys_clk_i    (sys_clk_i),
    .rst_i        (rst_i),
    .en_i         (run),
    .clear_i      (wr_div),
    .divisor_i    ({div_hi_r, div_lo_r}),
    .wide_i       (wide_divider_select_r),
    .high_speed_i (high_speed_select_r),
    .sync_i       (sync_r),
    .tick_o       (tick)
  );

  // --------------------------------------------------------------------
  // Clock pin events
  // --------------------------------------------------------------------
  wire m_active = tsr_busy_r | sync_rx;
  wire m_fall   = sync_master & m_active & tick & ck_o;
  wire s_fall   = sync_slave & ck_s3_r & ~ck_s2_r; // R08
  wire fall     = (m_fall | s_fall) & run;

  wire load_tsr = ~tsr_busy_r & tx_full_r & run &
                  (sync_tx | async_tx);
  wire rx_word  = sync_rx & fall && (rx_cnt_r == `SRB_LAST_BIT);
  wire [7:0] rx_next = {dt_s2_r, rx_shift_r[7:1]};

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
      dt_s1_r <= 1'b0;
      dt_s2_r <= 1'b0;
    end else begin
      ck_s1_r <= ck_i;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
      dt_s1_r <= dt_i;
      dt_s2_r <= dt_s1_r;
    end
  end

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      div_lo_r                <= `SRB_BYTE_RST;
      div_hi_r                <= `SRB_BYTE_RST;
      wide_divider_select_r   <= 1'b0; // R01
      master_r                <= 1'b0;
      tx_en_r                 <= 1'b0;
      sync_r                  <= 1'b0;
      high_speed_select_r     <= 1'b0;
      port_en_r               <= 1'b0;
      rx_en_r                 <= 1'b0;
      int_mask_r              <= `SRB_INT_RST;
      global_irq_enable_r     <= 1'b0;
      peripheral_irq_enable_r <= 1'b0;
    end else if (wr_i) begin
      case (addr_i)
        `SRB_REG_DIV_LO: div_lo_r <= wr_data_i; // R02
        `SRB_REG_DIV_HI: div_hi_r <= wr_data_i;
        `SRB_REG_RATE_CTRL:
          wide_divider_select_r <= wr_data_i[`SRB_RC_WIDE];
        `SRB_REG_TX_CTRL: begin
          master_r            <= wr_data_i[`SRB_TC_MASTER];
          tx_en_r             <= wr_data_i[`SRB_TC_TXEN];
          sync_r              <= wr_data_i[`SRB_TC_SYNC];
          high_speed_select_r <= wr_data_i[`SRB_TC_HS];
        end
        `SRB_REG_RX_CTRL: begin
          port_en_r <= wr_data_i[`SRB_XC_PORTEN];
          rx_en_r   <= wr_data_i[`SRB_XC_RXEN];
        end
        `SRB_REG_INT_MASK: int_mask_r <= wr_data_i[`SRB_INT_W-1:0];
        `SRB_REG_IRQ_CTRL: begin
          global_irq_enable_r     <= wr_data_i[`SRB_IC_GLOBAL];
          peripheral_irq_enable_r <= wr_data_i[`SRB_IC_PERI];
        end
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Transmit path
  // --------------------------------------------------------------------
  // The holding register refills on a write even in the cycle it empties
  // into the shifter, so no byte is lost at the hand-over.
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_hold_r  <= `SRB_BYTE_RST;
      tx_full_r  <= 1'b0;
      tsr_r      <= `SRB_BYTE_RST;
      tsr_busy_r <= 1'b0;
      tx_cnt_r   <= `SRB_CNT_RST;
      ck_o       <= 1'b1;
      dt_o       <= 1'b1;
    end else begin
      if (wr_tx_hold) begin
        tx_hold_r <= wr_data_i;
        tx_full_r <= 1'b1; // R13
      end else if (load_tsr) begin
        tx_full_r <= 1'b0; // R12
      end
      if (load_tsr) begin
        tsr_r      <= tx_hold_r; // R12
        tsr_busy_r <= 1'b1;
        tx_cnt_r   <= `SRB_CNT_RST;
        if (sync_r)
          dt_o <= tx_hold_r[0]; // R11
        else
          ck_o <= 1'b0;
      end else if (sync_tx & tsr_busy_r & fall) begin
        tsr_r    <= {1'b1, tsr_r[7:1]};
        dt_o     <= tsr_r[1]; // R11
        tx_cnt_r <= tx_cnt_r + 4'h1;
        if (tx_cnt_r == `SRB_LAST_BIT)
          tsr_busy_r <= 1'b0;
      end else if (async_tx & tsr_busy_r & tick) begin
        tx_cnt_r <= tx_cnt_r + 4'h1;
        if (tx_cnt_r < `SRB_STOP_IDX) begin
          ck_o  <= tsr_r[0];
          tsr_r <= {1'b1, tsr_r[7:1]};
        end else if (tx_cnt_r == `SRB_STOP_IDX) begin
          ck_o <= 1'b1;
        end else begin
          tsr_busy_r <= 1'b0;
        end
      end
      if (sync_master & m_active & tick & run)
        ck_o <= ~ck_o;
      else if (~port_en_r)
        ck_o <= ~sync_r;
    end
  end

  // --------------------------------------------------------------------
  // Receive path
  // --------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      rx_shift_r <= `SRB_BYTE_RST;
      rx_cnt_r   <= `SRB_CNT_RST;
      rx_hold_r  <= `SRB_BYTE_RST;
      rx_full_r  <= 1'b0;
    end else begin
      if (sync_rx & fall) begin
        rx_shift_r <= rx_next; // R09
        if (rx_cnt_r == `SRB_LAST_BIT)
          rx_cnt_r <= `SRB_CNT_RST;
        else
          rx_cnt_r <= rx_cnt_r + 4'h1;
      end else if (~sync_rx) begin
        rx_cnt_r <= `SRB_CNT_RST;
      end
      // A new word wins over a read that clears the flag in this cycle.
      if (rx_word & ~rx_full_r) begin
        rx_hold_r <= rx_next;
        rx_full_r <= 1'b1; // R09
      end else if (rx_word & rd_rx_hold) begin
        rx_hold_r <= rx_next;
        rx_full_r <= 1'b1;
      end else if (rd_rx_hold) begin
        rx_full_r <= 1'b0; // R10
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt status and outputs
  // --------------------------------------------------------------------
  always @* begin
    int_stat_nxt = rd_stat ? `SRB_INT_RST : int_stat_r;
    if (rx_word)
      int_stat_nxt[`SRB_INT_RX] = 1'b1; // R09
    if (rx_word & rx_full_r & ~rd_rx_hold)
      int_stat_nxt[`SRB_INT_OVR] = 1'b1;
    if (load_tsr)
      int_stat_nxt[`SRB_INT_TX] = 1'b1; // R12
    irq_nxt = peripheral_irq_enable_r & |(int_stat_nxt & int_mask_r);
  end

  always @* begin
    rd_nxt = `SRB_BYTE_RST;
    case (addr_i)
      `SRB_REG_DIV_LO: rd_nxt = div_lo_r;
      `SRB_REG_DIV_HI: rd_nxt = div_hi_r;
      `SRB_REG_RATE_CTRL: begin
        rd_nxt[`SRB_RC_WIDE] = wide_divider_select_r;
        rd_nxt[`SRB_RC_IDLE] = (rx_cnt_r == `SRB_CNT_RST);
      end
      `SRB_REG_TX_CTRL: begin
        rd_nxt[`SRB_TC_MASTER] = master_r;
        rd_nxt[`SRB_TC_TXEN]   = tx_en_r;
        rd_nxt[`SRB_TC_SYNC]   = sync_r;
        rd_nxt[`SRB_TC_HS]     = high_speed_select_r;
        rd_nxt[`SRB_TC_TRMT]   = ~tsr_busy_r;
      end
      `SRB_REG_RX_CTRL: begin
        rd_nxt[`SRB_XC_PORTEN] = port_en_r;
        rd_nxt[`SRB_XC_RXEN]   = rx_en_r;
      end
      `SRB_REG_RX_HOLD:  rd_nxt = rx_hold_r;
      `SRB_REG_INT_STAT: rd_nxt[`SRB_INT_W-1:0] = int_stat_r;
      `SRB_REG_INT_MASK: rd_nxt[`SRB_INT_W-1:0] = int_mask_r;
      `SRB_REG_IRQ_CTRL: begin
        rd_nxt[`SRB_IC_GLOBAL] = global_irq_enable_r;
        rd_nxt[`SRB_IC_PERI]   = peripheral_irq_enable_r;
      end
      default: rd_nxt = `SRB_BYTE_RST;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      int_stat_r    <= `SRB_INT_RST;
      rd_data_o     <= `SRB_BYTE_RST;
      irq_o         <= 1'b0;
      wake_o        <= 1'b0;
      vector_req_o  <= 1'b0;
      vector_addr_o <= `SRB_NO_VECTOR;
      ck_oe_o       <= 1'b0;
      dt_oe_o       <= 1'b0;
    end else begin
      int_stat_r    <= int_stat_nxt;
      rd_data_o     <= rd_i ? rd_nxt : `SRB_BYTE_RST;
      irq_o         <= irq_nxt;
      wake_o        <= sleep_i & irq_nxt; // R09 R12
      vector_req_o  <= irq_nxt & global_irq_enable_r; // R16
      vector_addr_o <= (irq_nxt & global_irq_enable_r) ? `SRB_ISR_VECTOR
                                                       : `SRB_NO_VECTOR;
      ck_oe_o       <= sync_master | async_tx; // R08
      dt_oe_o       <= sync_tx; // R11
    end
  end

endmodule
`default_nettype wire

// ---- srb_serial_port_sva.sv ----
// Assertion checker for the serial port register port, interrupt outputs
// and link pins. Sees only the ports of srb_serial_port; bound below.
`timescale 1ns/1ps
`default_nettype none

module srb_serial_port_sva (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  addr_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rd_data_o,
  input wire logic        sleep_i,
  input wire logic        ck_i,
  input wire logic        ck_oe_o,
  input wire logic        dt_o,
  input wire logic        dt_oe_o,
  input wire logic        irq_o,
  input wire logic        wake_o,
  input wire logic        vector_req_o,
  input wire logic [11:0] vector_addr_o
);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  chk_read_idle_zero:
    assert property (!$past(rd_i) |-> rd_data_o == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_unmapped_read:
    assert property (rd_i && addr_i >= 4'hA |=> rd_data_o == 8'h00)
    else $error("unmapped read returned nonzero data");
  chk_wake_in_sleep:
    assert property (wake_o |-> $past(sleep_i))
    else $error("wake raised outside sleep");
  chk_wake_follows_irq:
    assert property (irq_o && $past(sleep_i) |-> wake_o)
    else $error("interrupt during sleep without wake");
  chk_vector_addr:
    assert property (vector_req_o |-> vector_addr_o == 12'h004)
    else $error("vector request with wrong address");
  chk_vector_idle:
    assert property (!vector_req_o |-> vector_addr_o == 12'h000)
    else $error("vector address without request");
  // Pin inputs pass a two-stage synchroniser, so a fall shows late.
  chk_dt_after_fall:
    assert property (dt_oe_o && $past(dt_oe_o) && !ck_oe_o
                     && $changed(dt_o) |-> !$past(ck_i, 3))
    else $error("data pin changed while clock pin high");
  chk_irq_sticky:
    assert property ($fell(irq_o) |-> $past(rd_i) || $past(wr_i)
                     || $past(rd_i, 2) || $past(wr_i, 2)
                     || $past(rd_i, 3) || $past(wr_i, 3))
    else $error("interrupt dropped without a register access");

  cov_wake: cover property ($rose(wake_o));
  cov_vector: cover property ($rose(vector_req_o));
  cov_dt_drive: cover property ($rose(dt_oe_o));
endmodule

bind srb_serial_port srb_serial_port_sva u_sva (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i),
  .rd_i(rd_i), .rd_data_o(rd_data_o), .sleep_i(sleep_i), .ck_i(ck_i),
  .ck_oe_o(ck_oe_o), .dt_o(dt_o), .dt_oe_o(dt_oe_o), .irq_o(irq_o),
  .wake_o(wake_o), .vector_req_o(vector_req_o),
  .vector_addr_o(vector_addr_o)
);
`default_nettype wire

// ---- srb_sync_master.sv ----
// Model of an external synchronous master on the clock and data pins.
// Runs off the bench system clock; resolves both pin levels.
`timescale 1ns/1ps
`default_nettype none

module srb_sync_master (
  input  wire logic sys_clk_i,
  input  wire logic dev_ck_i,
  input  wire logic dev_ck_oe_i,
  input  wire logic dev_dt_i,
  input  wire logic dev_dt_oe_i,
  output wire logic ck_line_o,
  output wire logic dt_line_o
);
  // --------------------------------------------------------------------
  // Pin resolution and transfer
  // --------------------------------------------------------------------
  logic m_ck  = 1'b0;
  logic m_dt  = 1'b0;
  logic m_drv = 1'b0;
  logic tgl   = 1'b0;

  always @(posedge sys_clk_i) tgl <= ~tgl;
  assign ck_line_o = dev_ck_oe_i ? dev_ck_i : m_ck;
  // A released data line toggles so no stale bit can be read as data.
  assign dt_line_o = dev_dt_oe_i ? dev_dt_i : (m_drv ? m_dt : tgl);

  // Clock idles low between words; each high phase lasts eight cycles, each low phase nine.
  task automatic xfer(input logic [7:0] tx_b, input logic drive,
                      output logic [7:0] rx_b);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk_i);
      m_drv <= drive;
      m_dt  <= tx_b[i];
      repeat (8) @(posedge sys_clk_i);
      m_ck    <= 1'b1;
      rx_b[i] = dt_line_o;
      repeat (8) @(posedge sys_clk_i);
      m_ck <= 1'b0;
    end
    repeat (8) @(posedge sys_clk_i);
    m_drv <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- srb_serial_port_tb.sv ----
// Self-checking bench for srb_serial_port with a synchronous master model.
// Assumes srb_defines.vh on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "srb_defines.vh"

module srb_serial_port_tb;
  // --------------------------------------------------------------------
  // Stimulus, model and checks
  // --------------------------------------------------------------------
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic [3:0]  addr_i    = 4'h0;
  logic [7:0]  wr_data_i = 8'h00;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        sleep_i   = 1'b0;
  wire  [7:0]  rd_data_o;
  wire         ck_o, ck_oe_o, dt_o, dt_oe_o, ck_line, dt_line;
  wire         irq_o, wake_o, vector_req_o;
  wire  [11:0] vector_addr_o;
  int          fails       = 0;
  int          check_count = 0;

  always #25 sys_clk_i = ~sys_clk_i;

  srb_serial_port dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .sleep_i(sleep_i), .ck_i(ck_line),
    .ck_o(ck_o), .ck_oe_o(ck_oe_o), .dt_i(dt_line), .dt_o(dt_o),
    .dt_oe_o(dt_oe_o), .irq_o(irq_o), .wake_o(wake_o),
    .vector_req_o(vector_req_o), .vector_addr_o(vector_addr_o));
  srb_sync_master u_master (
    .sys_clk_i(sys_clk_i), .dev_ck_i(ck_o), .dev_ck_oe_i(ck_oe_o),
    .dev_dt_i(dt_o), .dev_dt_oe_i(dt_oe_o), .ck_line_o(ck_line),
    .dt_line_o(dt_line));

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask

  task automatic cmpv(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmp1(input logic g, input logic e);
    cmpv({31'h0, g}, {31'h0, e});
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    cmpv(32'(d), 32'(e));
  endtask

  task automatic wait_wake();
    int n;
    n = 0;
    while (wake_o !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    cmp1(wake_o, 1'b1);
  endtask

  task automatic wait_empty();
    logic [7:0] s;
    s = 8'h00;
    for (int n = 0; n < 8000 && s[1] !== 1'b1; n++)
      rd(`SRB_REG_TX_CTRL, s);
    cmp1(s[1], 1'b1);
  endtask

  task automatic t_regs();
    rd_chk(`SRB_REG_DIV_LO, 8'h00);
    rd_chk(`SRB_REG_DIV_HI, 8'h00);
    rd_chk(`SRB_REG_INT_STAT, 8'h00);
    rd_chk(`SRB_REG_INT_MASK, 8'h00);
    wr(4'hA, 8'hFF);
    rd_chk(4'hA, 8'h00);
    wr(`SRB_REG_DIV_LO, 8'hA7);
    rd_chk(`SRB_REG_DIV_LO, 8'hA7);
    $display("test regs done");
  endtask

  task automatic t_async_rate();
    int n, cnt, mult, exp;
    logic [7:0] hi;
    for (int k = 0; k < 4; k++) begin
      hi   = (k == 2) ? 8'h00 : 8'h01;
      mult = (k == 0) ? 64 : (k == 3) ? 4 : 16;
      exp  = mult * ((k > 1 ? int'(hi) * 256 : 0) + 4);
      wr(`SRB_REG_DIV_HI, hi);
      wr(`SRB_REG_DIV_LO, 8'h03);
      wr(`SRB_REG_RATE_CTRL, k[1] ? 8'h08 : 8'h00);
      wr(`SRB_REG_TX_CTRL, k[0] ? 8'h24 : 8'h20);
      wr(`SRB_REG_RX_CTRL, 8'h80);
      wr(`SRB_REG_TX_HOLD, 8'h55);
      n = 0;
      while (ck_o !== 1'b0 && n < 100) begin tick(1); n++; end
      while (ck_o !== 1'b1 && n < 2000) begin tick(1); n++; end
      n = 0;
      while (ck_o !== 1'b0 && n < 2000) begin tick(1); n++; end
      cmpv(32'(n), 32'(exp));
      wait_empty();
    end
    @(posedge sys_clk_i);
    sleep_i <= 1'b1;
    wr(`SRB_REG_TX_HOLD, 8'h0F);
    tick(20);
    hi[0] = 1'b1;
    cnt = 0;
    for (n = 0; n < 300; n++) begin
      tick(1);
      if (ck_o !== hi[0]) cnt++;
    end
    cmpv(32'(cnt), 32'h0);
    @(posedge sys_clk_i);
    sleep_i <= 1'b0;
    wait_empty();
    $display("test async_rate done");
  endtask

  task automatic t_sync_rx();
    logic [7:0] got;
    // Port off first, since the released async line reads as a clock fall.
    wr(`SRB_REG_RX_CTRL, 8'h00);
    wr(`SRB_REG_TX_CTRL, 8'h10);
    wr(`SRB_REG_INT_MASK, 8'h01);
    wr(`SRB_REG_RX_CTRL, 8'h90);
    for (int g = 0; g < 2; g++) begin
      wr(`SRB_REG_IRQ_CTRL, g ? 8'hC0 : 8'h40);
      rd(`SRB_REG_RX_HOLD, got);
      rd(`SRB_REG_INT_STAT, got);
      rd_chk(`SRB_REG_RATE_CTRL, 8'h48);
      @(posedge sys_clk_i);
      sleep_i <= 1'b1;
      u_master.xfer(g ? 8'h96 : 8'hC3, 1'b1, got);
      wait_wake();
      cmp1(irq_o, 1'b1);
      cmp1(vector_req_o, g[0]);
      cmpv(32'(vector_addr_o), g ? 32'h4 : 32'h0);
      cmp1(ck_oe_o, 1'b0);
      rd_chk(`SRB_REG_INT_STAT, 8'h01);
      rd_chk(`SRB_REG_RX_HOLD, g ? 8'h96 : 8'hC3);
      tick(3);
      cmp1(irq_o, 1'b0);
      @(posedge sys_clk_i);
      sleep_i <= 1'b0;
    end
    $display("test sync_rx done");
  endtask

  task automatic t_sync_tx();
    logic [7:0] got;
    wr(`SRB_REG_RX_CTRL, 8'h80);
    wr(`SRB_REG_TX_CTRL, 8'h30);
    wr(`SRB_REG_INT_MASK, 8'h02);
    wr(`SRB_REG_IRQ_CTRL, 8'h40);
    wr(`SRB_REG_TX_HOLD, 8'hA5);
    tick(3);
    rd_chk(`SRB_REG_INT_STAT, 8'h02);
    wr(`SRB_REG_TX_HOLD, 8'h3C);
    tick(3);
    cmp1(irq_o, 1'b0);
    cmp1(dt_oe_o, 1'b1);
    @(posedge sys_clk_i);
    sleep_i <= 1'b1;
    u_master.xfer(8'h00, 1'b0, got);
    cmpv(32'(got), 32'hA5);
    wait_wake();
    rd_chk(`SRB_REG_INT_STAT, 8'h02);
    u_master.xfer(8'h00, 1'b0, got);
    cmpv(32'(got), 32'h3C);
    @(posedge sys_clk_i);
    sleep_i <= 1'b0;
    $display("test sync_tx done");
  endtask

  task automatic t_sync_master();
    int n;
    logic b;
    wr(`SRB_REG_DIV_HI, 8'h00);
    wr(`SRB_REG_DIV_LO, 8'h03);
    wr(`SRB_REG_TX_CTRL, 8'hB4);
    wr(`SRB_REG_TX_HOLD, 8'h5A);
    tick(4);
    n = 0;
    b = ck_o;
    while (ck_o === b && n < 100) begin tick(1); n++; end
    b = ck_o;
    n = 0;
    while (ck_o === b && n < 100) begin tick(1); n++; end
    cmpv(32'(n), 32'h8);
    wait_empty();
    $display("test sync_master done");
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Longest path is two slow frames near 10k cycles each plus polling.
  initial begin
    repeat (80000) @(posedge sys_clk_i);
    fails++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_async_rate();
    t_sync_rx();
    t_sync_tx();
    t_sync_master();
    wrap_up();
  end
endmodule
`default_nettype wire
